// ---- logic/gpa_map.svh ----
/*
  Register offsets, field positions, reset values and comparator pin masks for the
  port A and port E pin logic. Assumes an 8-bit register port with byte offsets.
*/
// Functional notes
// - Port A has six pins, bits 0 to 5; upper register bits read zero.
// - Port A pin 4 is open drain: it only pulls low, never drives high.
// - Port A pin 4 is general I/O, timer external clock, or comparator output.
// - Port A pin 2 is general I/O, comparator input, or voltage reference output.
// - Port A pin 3 is general I/O, comparator input or output, per comparator mode.
// - Slave mode: port E pin 0 low with select low presents slave data to host.
// - Slave mode: port E pin 1 low with select low captures host data.
// - Slave mode: port E pin 2 is chip select; strobes ignored while it is high.
// - Port E pins are plain I/O unless slave mode is enabled, then bus inputs.
// - Direction bit set tri-states the pin; cleared drives the output latch.
// - Port reads return pin levels; writes update only the output latch.
// - Port A pins used as comparator inputs read back as zero.
`ifndef GPA_MAP_SVH
`define GPA_MAP_SVH

`define GPA_ADDR_PORT_A     8'h05
`define GPA_ADDR_SLAVE_DATA 8'h08
`define GPA_ADDR_PORT_E     8'h09
`define GPA_ADDR_CMP_CTRL   8'h1f
`define GPA_ADDR_DIR_A      8'h85
`define GPA_ADDR_DIR_E      8'h89
`define GPA_ADDR_VREF_CTRL  8'h9f

`define GPA_RST_DIR_A       6'h3f
`define GPA_RST_DIR_E       3'h7
`define GPA_RST_CMP_CTRL    4'h0
`define GPA_RST_VREF_CTRL   7'h00
`define GPA_RST_LATCH_A     6'h00
`define GPA_RST_LATCH_E     3'h0

`define GPA_CMP_MODE_OFF    3'h7
`define GPA_CMP_MODE_OUT    3'h6
`define GPA_MASK_ALL_ANALOG 6'h0f
`define GPA_MASK_OUT_MODE   6'h07
`define GPA_MASK_NONE       6'h00

`define GPA_DIR_E_IBF       7
`define GPA_DIR_E_OBF       6
`define GPA_DIR_E_INPUT_BUFFER_OVERFLOW      5
`define GPA_DIR_E_MODE      4
`define GPA_CMP_C2OUT       7
`define GPA_CMP_C1OUT       6
`define GPA_VREF_OE         6

`define GPA_PIN_VREF        2
`define GPA_PIN_CMP1_OUT    3
`define GPA_PIN_OPEN_DRAIN  4

`endif

// ---- logic/gpa_pkg.sv ----
/*
  Types shared by the port A and port E pin logic.
  Assumes the constants header supplies all numbers.
*/
package gpa_pkg;
  typedef enum logic [1:0] {
    GPA_IDLE  = 2'b00,
    GPA_WRITE = 2'b01,
    GPA_READ  = 2'b10
  } gpa_psp_state_t;
  typedef logic [7:0] gpa_byte_t;
endpackage

// ---- logic/gpa_psp_if.sv ----
/*
  Carrier between the register core and the parallel slave port.
  Assumes both ends run on mclk and host strobes arrive already synchronised.
*/
`timescale 1ns/1ns
interface gpa_psp_if;
  logic                enable;
  logic                rd_n;
  logic                wr_n;
  logic                cs_n;
  gpa_pkg::gpa_byte_t  host_din;
  logic                cpu_rd;
  logic                cpu_wr;
  gpa_pkg::gpa_byte_t  cpu_wdata;
  logic                input_buffer_overflow_clr;
  gpa_pkg::gpa_byte_t  in_buf;
  gpa_pkg::gpa_byte_t  out_buf;
  logic                host_oe;
  logic                input_buffer_full;
  logic                output_buffer_full;
  logic                input_buffer_overflow;
  modport core (output enable, rd_n, wr_n, cs_n, host_din, cpu_rd, cpu_wr, cpu_wdata,
                input_buffer_overflow_clr, input in_buf, out_buf, host_oe, input_buffer_full, output_buffer_full, input_buffer_overflow);
  modport psp  (input enable, rd_n, wr_n, cs_n, host_din, cpu_rd, cpu_wr, cpu_wdata,
                input_buffer_overflow_clr, output in_buf, out_buf, host_oe, input_buffer_full, output_buffer_full, input_buffer_overflow);
endinterface

// ---- logic/gpa_psp.sv ----
/*
  Parallel slave port: host read and write strobes against the slave data byte.
  Assumes strobes and host data were synchronised by the caller.
*/
`timescale 1ns/1ns
`include "gpa_map.svh"
module gpa_psp (
  input  wire logic mclk,
  input  wire logic rst_n,
  gpa_psp_if.psp    bus
);
  gpa_pkg::gpa_psp_state_t state;
  gpa_pkg::gpa_psp_state_t next_state;
  logic                    sel_rd;
  logic                    sel_wr;
  logic                    wr_done;
  logic                    rd_done;

  // A strobe only counts while the chip is selected and the mode is on.
  assign sel_rd  = bus.enable & ~bus.cs_n & ~bus.rd_n;
  assign sel_wr  = bus.enable & ~bus.cs_n & ~bus.wr_n;
  assign wr_done = (state == gpa_pkg::GPA_WRITE) & ~sel_wr;
  assign rd_done = (state == gpa_pkg::GPA_READ) & ~sel_rd;
  assign bus.host_oe = sel_rd;

  always_comb
  begin
    case (state)
      gpa_pkg::GPA_IDLE:  next_state = sel_wr ? gpa_pkg::GPA_WRITE :
                                       sel_rd ? gpa_pkg::GPA_READ : gpa_pkg::GPA_IDLE;
      gpa_pkg::GPA_WRITE: next_state = sel_wr ? gpa_pkg::GPA_WRITE : gpa_pkg::GPA_IDLE;
      gpa_pkg::GPA_READ:  next_state = sel_rd ? gpa_pkg::GPA_READ : gpa_pkg::GPA_IDLE;
      default:            next_state = gpa_pkg::GPA_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state <= gpa_pkg::GPA_IDLE;
    else
      state <= next_state;
  end

  // Data is tracked while the write strobe is low, so the last value before release lands.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bus.in_buf <= 8'h00;
    else if (sel_wr)
      bus.in_buf <= bus.host_din;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bus.out_buf <= 8'h00;
    else if (bus.cpu_wr)
      bus.out_buf <= bus.cpu_wdata;
  end

  // Hardware set wins over a clear that lands in the same cycle.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bus.input_buffer_full  <= 1'b0;
      bus.output_buffer_full  <= 1'b0;
      bus.input_buffer_overflow <= 1'b0;
    end
    else
    begin
      bus.input_buffer_full  <= wr_done | (bus.input_buffer_full & ~bus.cpu_rd);
      bus.output_buffer_full  <= bus.cpu_wr | (bus.output_buffer_full & ~rd_done);
      bus.input_buffer_overflow <= (wr_done & bus.input_buffer_full & ~bus.cpu_rd) | (bus.input_buffer_overflow & ~bus.input_buffer_overflow_clr);
    end
  end
endmodule // gpa_psp

// ---- logic/gpa_top.sv ----
/*
  Port A and port E pin logic with comparator and reference pin sharing and the
  parallel slave port. Assumes a single-cycle register port on mclk and pins
  that arrive asynchronously; the analog parts sit outside.
*/
`timescale 1ns/1ns
`include "gpa_map.svh"
module gpa_top (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [5:0] pa_in,
  output logic      [5:0] pa_out,
  output logic      [5:0] pa_oe,
  input  wire logic [2:0] pe_in,
  output logic      [2:0] pe_out,
  output logic      [2:0] pe_oe,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  input  wire logic       cmp1_result,
  input  wire logic       cmp2_result,
  output logic      [2:0] cmp_mode,
  output logic            cmp_input_switch,
  output logic            vref_enable,
  output logic            vref_pin_enable,
  output logic            vref_range,
  output logic      [3:0] vref_level,
  output logic            timer_external_clock_in
);
  logic [5:0] port_a_latch;
  logic [5:0] port_a_direction;
  logic [2:0] port_e_latch;
  logic [2:0] port_e_dir;
  logic       slave_port_enable;
  logic [3:0] comparator_control;
  logic [6:0] voltage_reference_control;
  logic [5:0] pa_meta;
  logic [5:0] pa_sync;
  logic [2:0] pe_meta;
  logic [2:0] pe_sync;
  logic [7:0] hd_meta;
  logic [7:0] hd_sync;
  logic [1:0] cmp_meta;
  logic [1:0] cmp_sync;
  logic [5:0] analog_mask;
  logic       cmp_out_mode;
  logic [5:0] pa_drive;
  logic [5:0] pa_read;
  logic       hit_pa;
  logic       hit_pe;
  logic       hit_cmp;
  logic       hit_dir_a;
  logic       hit_dir_e;
  logic       hit_vref;
  logic       hit_sd;
  logic [7:0] dir_e_view;
  logic [7:0] next_rdata;

  gpa_psp_if psp_bus ();

  // Which port A pins are taken as comparator inputs in a given mode.
  function automatic logic [5:0] gpa_analog_mask(input logic [2:0] mode);
    if (mode == `GPA_CMP_MODE_OFF)
      gpa_analog_mask = `GPA_MASK_NONE;
    else if (mode == `GPA_CMP_MODE_OUT)
      gpa_analog_mask = `GPA_MASK_OUT_MODE;
    else
      gpa_analog_mask = `GPA_MASK_ALL_ANALOG;
  endfunction

  function automatic logic gpa_hit(input logic [7:0] addr, input logic [7:0] target);
    gpa_hit = (addr == target);
  endfunction

  // Every pin and analog result crosses two flip-flops before any logic reads it.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pa_meta  <= 6'h00;
      pa_sync  <= 6'h00;
      pe_meta  <= 3'h7;
      pe_sync  <= 3'h7;
      hd_meta  <= 8'h00;
      hd_sync  <= 8'h00;
      cmp_meta <= 2'h0;
      cmp_sync <= 2'h0;
    end
    else
    begin
      pa_meta  <= pa_in;
      pa_sync  <= pa_meta;
      pe_meta  <= pe_in;
      pe_sync  <= pe_meta;
      hd_meta  <= host_data_in;
      hd_sync  <= hd_meta;
      cmp_meta <= {cmp2_result, cmp1_result};
      cmp_sync <= cmp_meta;
    end
  end

  assign hit_pa    = gpa_hit(reg_addr, `GPA_ADDR_PORT_A);
  assign hit_pe    = gpa_hit(reg_addr, `GPA_ADDR_PORT_E);
  assign hit_cmp   = gpa_hit(reg_addr, `GPA_ADDR_CMP_CTRL);
  assign hit_dir_a = gpa_hit(reg_addr, `GPA_ADDR_DIR_A);
  assign hit_dir_e = gpa_hit(reg_addr, `GPA_ADDR_DIR_E);
  assign hit_vref  = gpa_hit(reg_addr, `GPA_ADDR_VREF_CTRL);
  assign hit_sd    = gpa_hit(reg_addr, `GPA_ADDR_SLAVE_DATA);

  // Writes land in the latches only; a bit operation by the core reads pins first.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      port_a_latch <= `GPA_RST_LATCH_A;
      port_e_latch <= `GPA_RST_LATCH_E;
    end
    else if (reg_wr)
    begin
      if (hit_pa)
        port_a_latch <= reg_wdata[5:0];
      if (hit_pe)
        port_e_latch <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      port_a_direction  <= `GPA_RST_DIR_A;
      port_e_dir        <= `GPA_RST_DIR_E;
      slave_port_enable <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (hit_dir_a)
        port_a_direction <= reg_wdata[5:0];
      if (hit_dir_e)
      begin
        port_e_dir        <= reg_wdata[2:0];
        slave_port_enable <= reg_wdata[`GPA_DIR_E_MODE];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      comparator_control        <= `GPA_RST_CMP_CTRL;
      voltage_reference_control <= `GPA_RST_VREF_CTRL;
    end
    else if (reg_wr)
    begin
      if (hit_cmp)
        comparator_control <= reg_wdata[3:0];
      if (hit_vref)
        voltage_reference_control <= {reg_wdata[7:5], reg_wdata[3:0]};
    end
  end

  assign cmp_mode         = comparator_control[2:0];
  assign cmp_input_switch = comparator_control[3];
  assign vref_enable      = voltage_reference_control[6];
  assign vref_pin_enable  = voltage_reference_control[5];
  assign vref_range       = voltage_reference_control[4];
  assign vref_level       = voltage_reference_control[3:0];
  assign analog_mask      = gpa_analog_mask(cmp_mode);
  assign cmp_out_mode     = (cmp_mode == `GPA_CMP_MODE_OUT);

  // Pins 3 and 4 carry the comparator results in the output mode, else the latch.
  assign pa_drive = {port_a_latch[5],
                     cmp_out_mode ? cmp_sync[1] : port_a_latch[4],
                     cmp_out_mode ? cmp_sync[0] : port_a_latch[3],
                     port_a_latch[2:0]};

  // Pin 4 only ever sinks: its data line is low and the enable is on only while the value is low.
  assign pa_out = {pa_drive[5], 1'b0, pa_drive[3:0]};
  assign pa_oe  = {~port_a_direction[5],
                   ~port_a_direction[4] & ~pa_drive[4],
                   ~port_a_direction[3],
                   ~port_a_direction[2] & ~vref_pin_enable,
                   ~port_a_direction[1:0]};

  // The reference output is weak, so the digital driver is kept off the pin meanwhile.
  assign timer_external_clock_in = pa_sync[`GPA_PIN_OPEN_DRAIN];
  assign pa_read = pa_sync & ~analog_mask;

  // In slave mode the port E pins turn into bus inputs and are never driven.
  assign pe_out = port_e_latch;
  assign pe_oe  = slave_port_enable ? 3'h0 : ~port_e_dir;

  assign psp_bus.enable    = slave_port_enable;
  assign psp_bus.rd_n      = pe_sync[0];
  assign psp_bus.wr_n      = pe_sync[1];
  assign psp_bus.cs_n      = pe_sync[2];
  assign psp_bus.host_din  = hd_sync;
  assign psp_bus.cpu_rd    = reg_rd & hit_sd;
  assign psp_bus.cpu_wr    = reg_wr & hit_sd;
  assign psp_bus.cpu_wdata = reg_wdata;
  assign psp_bus.input_buffer_overflow_clr  = reg_wr & hit_dir_e & ~reg_wdata[`GPA_DIR_E_INPUT_BUFFER_OVERFLOW];

  gpa_psp u_psp (
    .mclk  (mclk),
    .rst_n (rst_n),
    .bus   (psp_bus.psp)
  );

  assign host_data_out = psp_bus.out_buf;
  assign host_data_oe  = psp_bus.host_oe;

  assign dir_e_view = {psp_bus.input_buffer_full, psp_bus.output_buffer_full, psp_bus.input_buffer_overflow,
                       slave_port_enable, 1'b0, port_e_dir};

  assign next_rdata =
    hit_pa    ? {2'b00, pa_read} :
    hit_pe    ? {5'h00, pe_sync} :
    hit_dir_a ? {2'b00, port_a_direction} :
    hit_dir_e ? dir_e_view :
    hit_cmp   ? {cmp_sync[1], cmp_sync[0], 2'b00, comparator_control} :
    hit_vref  ? {voltage_reference_control[6:4], 1'b0, voltage_reference_control[3:0]} :
    hit_sd    ? psp_bus.in_buf :
                8'h00;

  // Read data stands for exactly the cycle after the strobe, zero otherwise.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end
endmodule // gpa_top

// ---- tb/gpa_properties.sv ----
/*
  Checker for the port A and port E pin logic.
  Assumes it is bound to gpa_top and sees only its ports.
*/
`timescale 1ns/1ns
module gpa_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] pa_out,
  input wire logic [5:0] pa_oe,
  input wire logic [2:0] pe_in,
  input wire logic [2:0] pe_oe,
  input wire logic       host_data_oe,
  input wire logic [2:0] cmp_mode,
  input wire logic       vref_pin_enable
);
  wire logic wd5    = reg_wdata[5];
  wire logic rd_sel = !pe_in[0] && !pe_in[2];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_pa_rd;
    reg_rd && reg_addr == 8'h05;
  endsequence
  // The pins pass two flops before the bus turns round; two or three cycles are allowed.
  sequence s_sel_rd;
    $past(rd_sel, 2) || $past(rd_sel, 3);
  endsequence
  chk_od_low: assert property (pa_out[4] == 1'b0)
    else $error("pin 4 drives high");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  chk_hi_zero: assert property (s_pa_rd |=> reg_rdata[7:6] == 2'b00)
    else $error("upper port bits not zero");
  chk_analog_zero: assert property (s_pa_rd ##0 cmp_mode != 3'h7 |=> reg_rdata[2:0] == 3'h0)
    else $error("analog pins not zero");
  chk_dir_drive: assert property (reg_wr && reg_addr == 8'h85 |=> pa_oe[5] != $past(wd5))
    else $error("direction not applied");
  chk_pin5_latch: assert property (reg_wr && reg_addr == 8'h05 |=> pa_out[5] == $past(wd5))
    else $error("pin 5 latch wrong");
  chk_vref_pin: assert property (vref_pin_enable |-> !pa_oe[2])
    else $error("pin 2 driven with reference out");
  chk_slave_pins: assert property (host_data_oe |-> pe_oe == 3'h0)
    else $error("port E driven in slave mode");
  chk_rd_gate: assert property (host_data_oe |-> s_sel_rd)
    else $error("bus driven without read");
  chk_cs_gate: assert property (pe_in[2] [*4] |-> !host_data_oe)
    else $error("bus driven while deselected");
endmodule // gpa_chk
bind gpa_top gpa_chk i_chk (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pa_out, .pa_oe, .pe_in, .pe_oe, .host_data_oe, .cmp_mode, .vref_pin_enable);

// ---- tb/gpa_host.sv ----
/*
  Host processor model on the parallel slave port pins.
  Assumes the bench calls access() and routes strobe_n onto port E.
*/
`timescale 1ns/1ns
module gpa_host (
  input  wire logic       mclk,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe,
  output logic      [2:0] strobe_n,
  output logic      [7:0] bus
);
  logic [7:0] got;
  initial
  begin
    strobe_n = 3'h7;
    bus      = 8'h00;
    got      = 8'h00;
  end
  // Pins: 0 read strobe, 1 write strobe, 2 select, all active low.
  task automatic access(input logic [2:0] pins, input logic [7:0] d, input int hold);
    @(posedge mclk);
    strobe_n <= pins;
    bus      <= d;
    repeat (hold) @(posedge mclk);
    // An undriven data bus reads as the inverse, so a missing enable cannot pass.
    got       = host_data_oe ? host_data_out : ~host_data_out;
    strobe_n <= 3'h7;
    // A released bus shows the inverse, so stale data cannot pass.
    bus      <= ~d;
    repeat (5) @(posedge mclk);
  endtask
endmodule // gpa_host

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the port A and port E pin logic.
  Assumes the checker is bound and the host model sits on port E.
*/
`timescale 1ns/1ns
module testbench;
  logic       mclk, rst_n, reg_wr, reg_rd, cmp1_result, cmp2_result, host_data_oe;
  logic       timer_external_clock_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, host_data_in, host_data_out;
  logic [5:0] pa_in, pa_out, pa_oe;
  logic [2:0] pe_in, pe_out, pe_oe, host_pins, cmp_mode;
  logic       cmp_input_switch, vref_enable, vref_pin_enable, vref_range;
  logic [3:0] vref_level;
  logic [7:0] ra [4] = '{8'h85, 8'h89, 8'h1f, 8'h9f};
  logic [7:0] rv [4] = '{8'h3f, 8'h07, 8'h00, 8'h00};
  int         failures, n_checks;
  // Each port E pin shows the device where it drives, the host elsewhere.
  assign pe_in = (pe_oe & pe_out) | (~pe_oe & host_pins);
  gpa_top i_gpa_top (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pa_in, .pa_out, .pa_oe, .pe_in, .pe_out, .pe_oe, .host_data_in, .host_data_out,
    .host_data_oe, .cmp1_result, .cmp2_result, .cmp_mode, .cmp_input_switch,
    .vref_enable, .vref_pin_enable, .vref_range, .vref_level,
    .timer_external_clock_in);
  gpa_host i_gpa_host (.mclk, .host_data_out, .host_data_oe, .strobe_n(host_pins),
    .bus(host_data_in));
  always #2 mclk = ~mclk;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    end_of_test;
  end
  initial
  begin
    mclk        = 1'b0;
    rst_n       = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    pa_in       = 6'h2a;
    cmp1_result = 1'b0;
    cmp2_result = 1'b0;
    failures    = 0;
    n_checks    = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ra[i], rv[i]);
    rd(8'h42, 8'h00);
    wr(8'h9f, 8'hff);
    rd(8'h9f, 8'hef);
    chk("vref", {vref_enable, vref_pin_enable, vref_range, 1'b0, vref_level}, 8'hef);
    wr(8'h1f, 8'h07);
    wr(8'h85, 8'h00);
    wr(8'h05, 8'hff);
    #1 chk("pa_out", {2'h0, pa_out}, 8'h2f);
    chk("pa_oe", {2'h0, pa_oe}, 8'h2b);
    wr(8'h9f, 8'h00);
    wr(8'h05, 8'h00);
    #1 chk("pa_oe", {2'h0, pa_oe}, 8'h3f);
    wr(8'h85, 8'h3f);
    rd(8'h05, 8'h2a);
    wr(8'h1f, 8'h02);
    #1 chk("cmp_ctrl", {4'h0, cmp_input_switch, cmp_mode}, 8'h02);
    rd(8'h05, 8'h20);
    @(posedge mclk);
    pa_in       <= 6'h10;
    cmp1_result <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk("timer_clk", {7'h0, timer_external_clock_in}, 8'h01);
    rd(8'h1f, 8'h42);
    wr(8'h1f, 8'h06);
    wr(8'h85, 8'h00);
    #1 chk("pa_out", {2'h0, pa_out}, 8'h08);
    wr(8'h89, 8'h00);
    wr(8'h09, 8'h05);
    #1 chk("pe_oe", {5'h0, pe_oe}, 8'h07);
    // Pin levels reach the register port only after the two synchroniser stages.
    repeat (2) @(posedge mclk);
    rd(8'h09, 8'h05);
    wr(8'h89, 8'h17);
    #1 chk("pe_oe", {5'h0, pe_oe}, 8'h00);
    i_gpa_host.access(3'b001, 8'ha5, 5);
    rd(8'h89, 8'h97);
    rd(8'h08, 8'ha5);
    rd(8'h89, 8'h17);
    i_gpa_host.access(3'b101, 8'h3c, 5);
    rd(8'h89, 8'h17);
    i_gpa_host.access(3'b001, 8'h11, 5);
    i_gpa_host.access(3'b001, 8'h22, 5);
    rd(8'h89, 8'hb7);
    wr(8'h89, 8'h17);
    rd(8'h89, 8'h97);
    rd(8'h08, 8'h22);
    wr(8'h08, 8'h3c);
    rd(8'h89, 8'h57);
    i_gpa_host.access(3'b110, 8'h00, 6);
    chk("host_read", i_gpa_host.got, 8'hc3);
    rd(8'h89, 8'h57);
    i_gpa_host.access(3'b010, 8'h00, 6);
    chk("host_read", i_gpa_host.got, 8'h3c);
    rd(8'h89, 8'h17);
    end_of_test;
  end
endmodule // testbench
